// >>> hdl/pin_filter.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_filter
  import servo_params_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);

  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic level_next;

  // First stage feeds only the second
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg    <= pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule : pin_filter
`default_nettype wire

// >>> hdl/servo_params_pkg.sv
// Constants and carrier types for the servo motion parameter block
package servo_params_pkg;

  // Object dictionary indexes and subindexes
  localparam logic [15:0] IDX_TORQUE_SLOPE = 16'h6087;
  localparam logic [15:0] IDX_GEAR_RATIO   = 16'h6091;
  localparam logic [15:0] IDX_HOMING       = 16'h6098;
  localparam logic [7:0]  SUB_VALUE        = 8'h00;
  localparam logic [7:0]  SUB_GEAR_NUM     = 8'h01;
  localparam logic [7:0]  SUB_GEAR_DEN     = 8'h02;

  // Reset values
  localparam logic [31:0] RST_TORQUE_SLOPE = 32'h0000_0064;
  localparam logic [31:0] RST_GEAR_NUM     = 32'h0000_0001;
  localparam logic [31:0] RST_GEAR_DEN     = 32'h0000_0001;
  localparam logic [7:0]  RST_HOMING       = 8'h01;

  // Accepted ranges
  localparam logic [31:0] SLOPE_MAX  = 32'h7fff_ffff;
  localparam logic [31:0] GEAR_MIN   = 32'h0000_0001;
  localparam logic [7:0]  HOMING_MIN = 8'h01;
  localparam logic [7:0]  HOMING_MAX = 8'h23;

  // Homing method groups
  localparam logic [7:0] M_REV_OT_INDEX = 8'h01;
  localparam logic [7:0] M_FWD_OT_INDEX = 8'h02;
  localparam logic [7:0] M_SW_INDEX_LO  = 8'h03;
  localparam logic [7:0] M_SW_INDEX_HI  = 8'h0e;
  localparam logic [7:0] M_REV_OT_ONLY  = 8'h11;
  localparam logic [7:0] M_FWD_OT_ONLY  = 8'h12;
  localparam logic [7:0] M_SW_ONLY_LO   = 8'h13;
  localparam logic [7:0] M_SW_ONLY_HI   = 8'h1e;
  localparam logic [7:0] M_INDEX_LO     = 8'h21;
  localparam logic [7:0] M_INDEX_HI     = 8'h22;
  localparam logic [7:0] M_CUR_POS      = 8'h23;

  // Gear ratio window: 1/1000 up to 4000 * encoder resolution / 10000
  localparam logic [15:0] GEAR_MIN_SCALE = 16'h03e8;
  localparam logic [15:0] GEAR_MAX_MULT  = 16'h0fa0;
  localparam logic [15:0] GEAR_RES_DIV   = 16'h2710;

  // Slope is given per second; clock runs at 4 ns
  localparam longint SLOPE_TIME_S  = 1;
  localparam longint NS_PER_S      = 64'd1_000_000_000;
  localparam longint CLK_PERIOD_NS = 4;
  localparam logic [31:0] CYCLES_PER_SEC_DEF = 32'(SLOPE_TIME_S * NS_PER_S / CLK_PERIOD_NS);

  localparam int TORQUE_W = 16;

  typedef enum logic [2:0] {
    SRC_NONE      = 3'b000,
    SRC_REV_OT    = 3'b001,
    SRC_FWD_OT    = 3'b010,
    SRC_ORIGIN_SW = 3'b011,
    SRC_INDEX     = 3'b100,
    SRC_CUR_POS   = 3'b101
  } home_src_e;

  typedef struct packed {
    home_src_e decel;
    home_src_e origin;
  } home_sel_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } od_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } od_resp_s;

  typedef struct packed {
    logic rev_ot;
    logic fwd_ot;
    logic origin_sw;
    logic index;
  } home_pins_s;

endpackage : servo_params_pkg

// >>> hdl/servo_ratio_homing_params.sv
// Torque slope, gear ratio and homing method parameters with their effects
`timescale 1ns/1ps
`default_nettype none
// How it works
// - In torque mode the torque command moves toward its target by no more than the slope per second.
// - The gear numerator sits at subindex 1, takes values from 1 upward and resets to 1.
// - The gear denominator sits at subindex 2, takes values from 1 upward and resets to 1.
// - A gear ratio outside its allowed window raises the gear ratio range fault.
// - The homing method selector takes 1 to 35 and resets to method 1.
// - Methods 3-14 use origin switch then index pulse, methods 19-30 the origin switch for both.
// - Method 1 slows on reverse overtravel and method 2 on forward overtravel, both homing on index.
// - New values reach the active set only while the drive is stopped, the old ones staying active in motion; the gear fault checks written values at once.
module servo_ratio_homing_params
  import servo_params_pkg::*;
#(
  parameter logic [31:0] CYCLES_PER_SEC = CYCLES_PER_SEC_DEF,
  parameter logic [31:0] ENC_RES        = 32'h0000_2710
)(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Object dictionary access
  input  wire od_req_s              od_req,
  output od_resp_s                  od_resp,
  // Drive state
  input  wire logic                 drive_stopped,
  input  wire logic                 profile_torque_operation,
  input  wire logic                 homing_operation,
  input  wire logic [TORQUE_W-1:0]  target_torque,
  // Homing pins
  input  wire home_pins_s           home_pins,
  // Active parameters and results
  output logic [TORQUE_W-1:0]       torque_cmd,
  output logic [31:0]               gear_num_active,
  output logic [31:0]               gear_den_active,
  output logic                      gear_ratio_range_fault,
  output home_sel_s                 homing_sel,
  output logic                      decel_hit,
  output logic                      origin_hit
);

  // Written values, and the copies that drive the logic
  logic [31:0] slope_pend_reg, slope_pend_next, slope_act_reg, slope_act_next;
  logic [31:0] num_pend_reg, num_pend_next, num_act_reg, num_act_next;
  logic [31:0] den_pend_reg, den_pend_next, den_act_reg, den_act_next;
  logic [7:0]  meth_pend_reg, meth_pend_next, meth_act_reg, meth_act_next;
  od_resp_s    resp_reg, resp_next;

  // Ramp state
  logic [31:0]         ramp_q_reg, ramp_q_next, ramp_r_reg, ramp_r_next;
  logic [31:0]         acc_reg, acc_next;
  logic [TORQUE_W-1:0] cmd_reg, cmd_next;
  logic [32:0]         acc_sum, step, diff, mag;

  // Decode state
  home_sel_s  sel_reg, sel_next;
  logic       fault_reg, fault_next, dhit_reg, dhit_next, ohit_reg, ohit_next;
  home_pins_s pins_f;

  function automatic logic gear_in_range(input logic [31:0] num, input logic [31:0] den);
    logic [79:0] n80;
    logic [79:0] d80;
    n80 = 80'(num);
    d80 = 80'(den);
    return (n80 * 80'(GEAR_MIN_SCALE) >= d80) &&
           (n80 * 80'(GEAR_RES_DIV) <= 80'(GEAR_MAX_MULT) * 80'(ENC_RES) * d80);
  endfunction : gear_in_range

  function automatic home_sel_s decode_method(input logic [7:0] m);
    home_sel_s s;
    s = '{decel: SRC_NONE, origin: SRC_NONE};
    if (m == M_REV_OT_INDEX) begin
      s = '{decel: SRC_REV_OT, origin: SRC_INDEX};
    end else if (m == M_FWD_OT_INDEX) begin
      s = '{decel: SRC_FWD_OT, origin: SRC_INDEX};
    end else if (m >= M_SW_INDEX_LO && m <= M_SW_INDEX_HI) begin
      s = '{decel: SRC_ORIGIN_SW, origin: SRC_INDEX};
    end else if (m == M_REV_OT_ONLY) begin
      s = '{decel: SRC_REV_OT, origin: SRC_REV_OT};
    end else if (m == M_FWD_OT_ONLY) begin
      s = '{decel: SRC_FWD_OT, origin: SRC_FWD_OT};
    end else if (m >= M_SW_ONLY_LO && m <= M_SW_ONLY_HI) begin
      s = '{decel: SRC_ORIGIN_SW, origin: SRC_ORIGIN_SW};
    end else if (m >= M_INDEX_LO && m <= M_INDEX_HI) begin
      s = '{decel: SRC_NONE, origin: SRC_INDEX};
    end else if (m == M_CUR_POS) begin
      s = '{decel: SRC_NONE, origin: SRC_CUR_POS};
    end
    return s;
  endfunction : decode_method

  function automatic logic pick_pin(input home_src_e src, input home_pins_s p);
    logic hit;
    hit = 1'b0;
    case (src)
      SRC_REV_OT:    hit = p.rev_ot;
      SRC_FWD_OT:    hit = p.fwd_ot;
      SRC_ORIGIN_SW: hit = p.origin_sw;
      SRC_INDEX:     hit = p.index;
      SRC_CUR_POS:   hit = 1'b1;
      default:       hit = 1'b0;
    endcase
    return hit;
  endfunction : pick_pin

  pin_filter u_rev_ot (.mclk(mclk), .sys_rst(sys_rst), .pin(home_pins.rev_ot),    .level(pins_f.rev_ot));
  pin_filter u_fwd_ot (.mclk(mclk), .sys_rst(sys_rst), .pin(home_pins.fwd_ot),    .level(pins_f.fwd_ot));
  pin_filter u_orig   (.mclk(mclk), .sys_rst(sys_rst), .pin(home_pins.origin_sw), .level(pins_f.origin_sw));
  pin_filter u_index  (.mclk(mclk), .sys_rst(sys_rst), .pin(home_pins.index),     .level(pins_f.index));

  // Object dictionary writes and reads; out-of-range writes are refused whole
  always_comb begin
    slope_pend_next = slope_pend_reg;
    num_pend_next   = num_pend_reg;
    den_pend_next   = den_pend_reg;
    meth_pend_next  = meth_pend_reg;
    resp_next       = '{ack: 1'b0, err: 1'b0, rdata: resp_reg.rdata};
    if (od_req.wr) begin
      resp_next.err = 1'b1;
      if (od_req.index == IDX_TORQUE_SLOPE && od_req.sub == SUB_VALUE) begin
        if (od_req.data <= SLOPE_MAX) begin
          slope_pend_next = od_req.data;
          resp_next.err   = 1'b0;
        end
      end else if (od_req.index == IDX_GEAR_RATIO && od_req.sub == SUB_GEAR_NUM) begin
        if (od_req.data >= GEAR_MIN) begin
          num_pend_next = od_req.data;
          resp_next.err = 1'b0;
        end
      end else if (od_req.index == IDX_GEAR_RATIO && od_req.sub == SUB_GEAR_DEN) begin
        if (od_req.data >= GEAR_MIN) begin
          den_pend_next = od_req.data;
          resp_next.err = 1'b0;
        end
      end else if (od_req.index == IDX_HOMING && od_req.sub == SUB_VALUE) begin
        if (od_req.data >= 32'(HOMING_MIN) && od_req.data <= 32'(HOMING_MAX)) begin
          meth_pend_next = od_req.data[7:0];
          resp_next.err  = 1'b0;
        end
      end
      resp_next.ack = ~resp_next.err;
    end else if (od_req.rd) begin
      resp_next.ack = 1'b1;
      if (od_req.index == IDX_TORQUE_SLOPE && od_req.sub == SUB_VALUE) begin
        resp_next.rdata = slope_pend_reg;
      end else if (od_req.index == IDX_GEAR_RATIO && od_req.sub == SUB_GEAR_NUM) begin
        resp_next.rdata = num_pend_reg;
      end else if (od_req.index == IDX_GEAR_RATIO && od_req.sub == SUB_GEAR_DEN) begin
        resp_next.rdata = den_pend_reg;
      end else if (od_req.index == IDX_HOMING && od_req.sub == SUB_VALUE) begin
        resp_next.rdata = 32'(meth_pend_reg);
      end else begin
        resp_next = '{ack: 1'b0, err: 1'b1, rdata: '0};
      end
    end
  end

  // Copy into the active set only at standstill, so motion never sees a change mid-move
  always_comb begin
    slope_act_next = slope_act_reg;
    num_act_next   = num_act_reg;
    den_act_next   = den_act_reg;
    meth_act_next  = meth_act_reg;
    ramp_q_next    = ramp_q_reg;
    ramp_r_next    = ramp_r_reg;
    if (drive_stopped) begin
      slope_act_next = slope_pend_reg;
      num_act_next   = num_pend_reg;
      den_act_next   = den_pend_reg;
      meth_act_next  = meth_pend_reg;
      ramp_q_next    = slope_pend_reg / CYCLES_PER_SEC;
      ramp_r_next    = slope_pend_reg % CYCLES_PER_SEC;
    end
  end

  // Slope split into whole units per cycle plus a remainder carried across cycles
  always_comb begin
    acc_sum  = {1'b0, acc_reg} + {1'b0, ramp_r_reg};
    acc_next = acc_sum[31:0];
    step     = {1'b0, ramp_q_reg};
    if (acc_sum >= {1'b0, CYCLES_PER_SEC}) begin
      acc_next = 32'(acc_sum - {1'b0, CYCLES_PER_SEC});
      step     = step + 33'h1;
    end
    diff = {{(33-TORQUE_W){target_torque[TORQUE_W-1]}}, target_torque}
         - {{(33-TORQUE_W){cmd_reg[TORQUE_W-1]}}, cmd_reg};
    mag  = diff[32] ? 33'(-diff) : diff;
    cmd_next = cmd_reg;
    if (!profile_torque_operation) begin
      cmd_next = '0;
      acc_next = '0;
    end else if (mag <= step) begin
      cmd_next = target_torque;
    end else if (diff[32]) begin
      cmd_next = cmd_reg - step[TORQUE_W-1:0];
    end else begin
      cmd_next = cmd_reg + step[TORQUE_W-1:0];
    end
  end

  // Homing sources, pin selection and gear window check
  always_comb begin
    sel_next   = decode_method(meth_act_reg);
    dhit_next  = homing_operation & pick_pin(sel_reg.decel, pins_f);
    ohit_next  = homing_operation & pick_pin(sel_reg.origin, pins_f);
    fault_next = ~gear_in_range(num_pend_reg, den_pend_reg);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slope_pend_reg <= RST_TORQUE_SLOPE;
      num_pend_reg   <= RST_GEAR_NUM;
      den_pend_reg   <= RST_GEAR_DEN;
      meth_pend_reg  <= RST_HOMING;
      slope_act_reg  <= RST_TORQUE_SLOPE;
      num_act_reg    <= RST_GEAR_NUM;
      den_act_reg    <= RST_GEAR_DEN;
      meth_act_reg   <= RST_HOMING;
      ramp_q_reg     <= '0;
      ramp_r_reg     <= '0;
      resp_reg       <= '0;
      acc_reg        <= '0;
      cmd_reg        <= '0;
      sel_reg        <= '{decel: SRC_NONE, origin: SRC_NONE};
      dhit_reg       <= 1'b0;
      ohit_reg       <= 1'b0;
      fault_reg      <= 1'b0;
    end else begin
      slope_pend_reg <= slope_pend_next;
      num_pend_reg   <= num_pend_next;
      den_pend_reg   <= den_pend_next;
      meth_pend_reg  <= meth_pend_next;
      slope_act_reg  <= slope_act_next;
      num_act_reg    <= num_act_next;
      den_act_reg    <= den_act_next;
      meth_act_reg   <= meth_act_next;
      ramp_q_reg     <= ramp_q_next;
      ramp_r_reg     <= ramp_r_next;
      resp_reg       <= resp_next;
      acc_reg        <= acc_next;
      cmd_reg        <= cmd_next;
      sel_reg        <= sel_next;
      dhit_reg       <= dhit_next;
      ohit_reg       <= ohit_next;
      fault_reg      <= fault_next;
    end
  end

  assign od_resp                = resp_reg;
  assign torque_cmd             = cmd_reg;
  assign gear_num_active        = num_act_reg;
  assign gear_den_active        = den_act_reg;
  assign gear_ratio_range_fault = fault_reg;
  assign homing_sel             = sel_reg;
  assign decel_hit              = dhit_reg;
  assign origin_hit             = ohit_reg;

  // Helper for the ramp check: size of the last command step
  logic [TORQUE_W-1:0] cmd_prev_reg;
  logic [32:0]         cmd_delta;
  always_ff @(posedge mclk) begin
    cmd_prev_reg <= cmd_reg;
  end
  always_comb begin
    cmd_delta = {{(33-TORQUE_W){cmd_reg[TORQUE_W-1]}}, cmd_reg}
              - {{(33-TORQUE_W){cmd_prev_reg[TORQUE_W-1]}}, cmd_prev_reg};
    if (cmd_delta[32]) begin
      cmd_delta = 33'(-cmd_delta);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_num_zero_write;
    od_req.wr && od_req.index == IDX_GEAR_RATIO && od_req.sub == SUB_GEAR_NUM && od_req.data == 32'h0;
  endsequence
  sequence s_den_zero_write;
    od_req.wr && od_req.index == IDX_GEAR_RATIO && od_req.sub == SUB_GEAR_DEN && od_req.data == 32'h0;
  endsequence
  // Homing must stay on for the decode cycle as well, or the hit legally drops
  sequence s_cur_pos_homing;
    (meth_act_reg == M_CUR_POS && homing_operation) ##1 homing_operation;
  endsequence

  a_ramp_step_limit: assert property (
    profile_torque_operation && $past(profile_torque_operation) && !$past(sys_rst)
    |-> cmd_delta <= {1'b0, $past(ramp_q_reg)} + 33'h1)
    else $error("torque command stepped faster than the slope allows");
  a_num_zero_refused: assert property (
    s_num_zero_write |=> num_pend_reg == $past(num_pend_reg) && resp_reg.err && num_pend_reg != 32'h0)
    else $error("zero numerator was taken");
  a_den_zero_refused: assert property (
    s_den_zero_write |=> den_pend_reg == $past(den_pend_reg) && resp_reg.err && den_pend_reg != 32'h0)
    else $error("zero denominator was taken");
  a_gear_fault_low: assert property (
    80'(num_pend_reg) * 80'(GEAR_MIN_SCALE) < 80'(den_pend_reg) |=> gear_ratio_range_fault)
    else $error("gear ratio below window without fault");
  a_method_in_range: assert property (
    meth_act_reg >= HOMING_MIN && meth_act_reg <= HOMING_MAX)
    else $error("homing method outside 1 to 35");
  a_switch_index_pair: assert property (
    meth_act_reg >= M_SW_INDEX_LO && meth_act_reg <= M_SW_INDEX_HI
    |=> homing_sel.decel == SRC_ORIGIN_SW && homing_sel.origin == SRC_INDEX)
    else $error("methods 3 to 14 decoded wrongly");
  a_overtravel_index: assert property (
    meth_act_reg == M_REV_OT_INDEX |=> homing_sel.decel == SRC_REV_OT && homing_sel.origin == SRC_INDEX)
    else $error("method 1 decoded wrongly");
  a_current_position: assert property (
    s_cur_pos_homing |=> origin_hit && !decel_hit)
    else $error("method 35 did not take the current position");
  a_hold_in_motion: assert property (
    !drive_stopped |=> num_act_reg == $past(num_act_reg) && den_act_reg == $past(den_act_reg)
                    && meth_act_reg == $past(meth_act_reg) && slope_act_reg == $past(slope_act_reg))
    else $error("active parameter changed while moving");
  a_apply_at_stop: assert property (
    drive_stopped |=> num_act_reg == $past(num_pend_reg) && meth_act_reg == $past(meth_pend_reg))
    else $error("stopped drive did not take the new value");

endmodule : servo_ratio_homing_params
`default_nettype wire

// >>> test/od_master_model.sv
// Fieldbus master model that issues object dictionary requests
`timescale 1ns/1ps
`default_nettype none
module od_master_model
  import servo_params_pkg::*;
(
  // Clock
  input  wire logic     mclk,
  // Request and answer
  output var od_req_s   od_req,
  input  wire od_resp_s od_resp
);
  initial od_req = '0;

  // One request per call; released fields show inverted data so stale values never look valid
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] data, output logic ack, output logic err,
                        output logic [31:0] rdata);
    @(posedge mclk);
    od_req <= '{wr: wr, rd: !wr, index: idx, sub: sub, data: data};
    @(posedge mclk);
    od_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, sub: ~sub, data: ~data};
    #1;
    ack   = od_resp.ack;
    err   = od_resp.err;
    rdata = od_resp.rdata;
  endtask : access
endmodule : od_master_model
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the motion parameter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import servo_params_pkg::*;
  // Short second keeps the ramp test brief
  localparam logic [31:0] CPS = 32'h0000_0010;
  logic                mclk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                drive_stopped = 1'b1;
  logic                profile_torque_operation = 1'b0;
  logic                homing_operation = 1'b0;
  logic [TORQUE_W-1:0] target_torque = '0;
  home_pins_s          home_pins = '0;
  od_req_s             od_req;
  od_resp_s            od_resp;
  logic [TORQUE_W-1:0] torque_cmd;
  logic [31:0]         gear_num_active;
  logic [31:0]         gear_den_active;
  logic                gear_ratio_range_fault;
  home_sel_s           homing_sel;
  logic                decel_hit;
  logic                origin_hit;
  int                  error_cnt = 0;
  int                  check_count = 0;

  always #2 mclk = ~mclk;

  od_master_model master_u (.mclk(mclk), .od_req(od_req), .od_resp(od_resp));

  servo_ratio_homing_params #(.CYCLES_PER_SEC(CPS)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .od_req(od_req), .od_resp(od_resp),
    .drive_stopped(drive_stopped), .profile_torque_operation(profile_torque_operation),
    .homing_operation(homing_operation), .target_torque(target_torque), .home_pins(home_pins),
    .torque_cmd(torque_cmd), .gear_num_active(gear_num_active), .gear_den_active(gear_den_active),
    .gear_ratio_range_fault(gear_ratio_range_fault), .homing_sel(homing_sel),
    .decel_hit(decel_hit), .origin_hit(origin_hit));

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic wr_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data,
                        input logic exp_err);
    logic        a;
    logic        e;
    logic [31:0] r;
    master_u.access(1'b1, idx, sub, data, a, e, r);
    chk({31'h0, exp_err}, {31'h0, e});
    chk({31'h0, !exp_err}, {31'h0, a});
  endtask : wr_chk

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    logic        a;
    logic        e;
    logic [31:0] r;
    master_u.access(1'b0, idx, sub, 32'h0, a, e, r);
    chk(32'h1, {31'h0, a});
    chk(exp, r);
  endtask : rd_chk

  // Expected deceleration and origin sources of one method
  function automatic home_sel_s exp_sel(input int m);
    if (m == 1) return '{SRC_REV_OT, SRC_INDEX};
    if (m == 2) return '{SRC_FWD_OT, SRC_INDEX};
    if (m >= 3 && m <= 14) return '{SRC_ORIGIN_SW, SRC_INDEX};
    if (m == 17) return '{SRC_REV_OT, SRC_REV_OT};
    if (m == 18) return '{SRC_FWD_OT, SRC_FWD_OT};
    if (m >= 19 && m <= 30) return '{SRC_ORIGIN_SW, SRC_ORIGIN_SW};
    if (m == 33 || m == 34) return '{SRC_NONE, SRC_INDEX};
    if (m == 35) return '{SRC_NONE, SRC_CUR_POS};
    return '{SRC_NONE, SRC_NONE};
  endfunction : exp_sel

  task automatic test_reset();
    rd_chk(IDX_TORQUE_SLOPE, SUB_VALUE, 32'h0000_0064);
    rd_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, 32'h0000_0001);
    rd_chk(IDX_GEAR_RATIO, SUB_GEAR_DEN, 32'h0000_0001);
    rd_chk(IDX_HOMING, SUB_VALUE, 32'h0000_0001);
    chk(32'(exp_sel(1)), 32'(homing_sel));
    chk(32'h0, 32'(torque_cmd));
    $display("test reset done");
  endtask : test_reset

  task automatic test_refuse();
    wr_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, 32'h0, 1'b1);
    wr_chk(IDX_GEAR_RATIO, SUB_GEAR_DEN, 32'h0, 1'b1);
    wr_chk(IDX_HOMING, SUB_VALUE, 32'h0, 1'b1);
    wr_chk(IDX_HOMING, SUB_VALUE, 32'h24, 1'b1);
    wr_chk(IDX_TORQUE_SLOPE, SUB_VALUE, 32'h8000_0000, 1'b1);
    wr_chk(IDX_GEAR_RATIO, 8'h03, 32'h5, 1'b1);
    wr_chk(16'h6099, SUB_VALUE, 32'h5, 1'b1);
    rd_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, 32'h1);
    rd_chk(IDX_GEAR_RATIO, SUB_GEAR_DEN, 32'h1);
    rd_chk(IDX_HOMING, SUB_VALUE, 32'h1);
    $display("test refuse done");
  endtask : test_refuse

  task automatic test_stopped();
    @(posedge mclk) drive_stopped <= 1'b0;
    wr_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, 32'h5, 1'b0);
    rd_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, 32'h5);
    repeat (6) @(posedge mclk);
    #1 chk(32'h1, gear_num_active);
    @(posedge mclk) drive_stopped <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(32'h5, gear_num_active);
    wr_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, 32'h1, 1'b0);
    $display("test stopped done");
  endtask : test_stopped

  task automatic test_methods();
    for (int m = 1; m <= 35; m++) begin
      wr_chk(IDX_HOMING, SUB_VALUE, 32'(m), 1'b0);
      repeat (4) @(posedge mclk);
      #1 chk(32'(exp_sel(m)), 32'(homing_sel));
    end
    $display("test methods done");
  endtask : test_methods

  task automatic test_pins();
    wr_chk(IDX_HOMING, SUB_VALUE, 32'h13, 1'b0);
    @(posedge mclk) homing_operation <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk(32'h0, {31'h0, origin_hit});
    @(posedge mclk) home_pins.origin_sw <= 1'b1;
    for (int i = 0; i < 10 && origin_hit !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(32'h1, {31'h0, origin_hit});
    chk(32'h1, {31'h0, decel_hit});
    @(posedge mclk) home_pins.origin_sw <= 1'b0;
    wr_chk(IDX_HOMING, SUB_VALUE, 32'h23, 1'b0);
    repeat (4) @(posedge mclk);
    #1 chk(32'h1, {31'h0, origin_hit});
    chk(32'h0, {31'h0, decel_hit});
    @(posedge mclk) homing_operation <= 1'b0;
    $display("test pins done");
  endtask : test_pins

  task automatic test_fault();
    logic [31:0] num [5] = '{32'd4000, 32'd4001, 32'd1, 32'd1, 32'd1};
    logic [31:0] den [5] = '{32'd1, 32'd1, 32'd1000, 32'd1001, 32'd1};
    logic        flt [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr_chk(IDX_GEAR_RATIO, SUB_GEAR_NUM, num[i], 1'b0);
      wr_chk(IDX_GEAR_RATIO, SUB_GEAR_DEN, den[i], 1'b0);
      @(posedge mclk);
      #1 chk({31'h0, flt[i]}, {31'h0, gear_ratio_range_fault});
      chk(num[i], gear_num_active);
      chk(den[i], gear_den_active);
    end
    $display("test fault done");
  endtask : test_fault

  task automatic test_ramp();
    // 32 per second over a 16 cycle second gives exactly 2 per cycle
    wr_chk(IDX_TORQUE_SLOPE, SUB_VALUE, 32'h20, 1'b0);
    @(posedge mclk) target_torque <= 16'h000a;
    repeat (3) @(posedge mclk);
    profile_torque_operation <= 1'b1;
    for (int i = 0; i < 8 && torque_cmd === 16'h0; i++) begin
      @(posedge mclk);
      #1;
    end
    for (int k = 1; k <= 5; k++) begin
      chk(32'(2 * k), 32'(torque_cmd));
      @(posedge mclk);
      #1;
    end
    chk(32'ha, 32'(torque_cmd));
    @(posedge mclk) profile_torque_operation <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(32'h0, 32'(torque_cmd));
    $display("test ramp done");
  endtask : test_ramp

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge mclk);
    test_reset();
    test_refuse();
    test_stopped();
    test_methods();
    test_pins();
    test_fault();
    test_ramp();
    end_sim();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #40000;
    error_cnt++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
